// ---- dv/srst_chk.sv ----
// soft reset checker
`timescale 1ns/1ps
module srst_chk (
  input wire       core_clk, sys_rst, regWrEn,
  input wire [7:0] regAddr, regWrData, regRdData,
  input wire       rxResetOut, coreLogicResetOut, regFileResetOut, strapReloadOut,
  input wire       defaultRestoreOut
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire wr = regWrEn && regAddr == 8'h01;
  wire lo = wr && regWrData[1:0] == 2'b01;
  rx_pulse_a: assert property (wr && regWrData[4] |=> rxResetOut [*4]) else $error("rx");
  full_reset_a:
    assert property (wr && regWrData[1] |=> regFileResetOut && coreLogicResetOut) else $error("f");
  logic_only_a: assert property (lo |=> coreLogicResetOut > regFileResetOut) else $error("l");
  strap_reload_a: assert property (lo |=> strapReloadOut) else $error("s");
  restore_pair_a: assert property (strapReloadOut == defaultRestoreOut) else $error("d");
  reserved_zero_a: assert property ((regRdData & 8'hEC) == 8'h00) else $error("r");
  cover property (lo);
  cover property (wr && regWrData[4]);
  cover property (regFileResetOut);
endmodule // srst_chk
bind srst_soft_reset_control srst_chk i_srst_chk (.*);

// ---- dv/srst_soft_reset_control_tb.sv ----
// soft reset bench
`timescale 1ns/1ps
module srst_soft_reset_control_tb;
  logic core_clk = 0, sys_rst = 1, regWrEn = 0, regRdEn = 0;
  logic [7:0] regAddr = 8'h0, regWrData = 8'h0;
  wire [7:0] regRdData;
  wire rxResetOut, coreLogicResetOut, regFileResetOut, strapReloadOut, defaultRestoreOut;
  wire [7:0] outs = {3'h0, rxResetOut, coreLogicResetOut, regFileResetOut, strapReloadOut,
                     defaultRestoreOut};
  int numErrors, checked;
  srst_soft_reset_control i_srst_soft_reset_control (.*);
  initial forever #2 core_clk = ~core_clk;
  task automatic chk(string nm, logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      numErrors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // write then read in the next cycle, before self-clear
  task automatic rd(logic [7:0] d, exp);
    @(posedge core_clk);
    #1 regAddr = 8'h01;
    regWrData = d;
    regWrEn = 1;
    @(posedge core_clk);
    #1 regWrEn = 0;
    regRdEn = 1;
    @(posedge core_clk);
    #1 regRdEn = 0;
    chk("rdData", regRdData, exp);
    repeat (4) @(posedge core_clk);
  endtask
  // reset asserted in the middle of active pulses
  task automatic midReset;
    @(posedge core_clk);
    #1 regAddr = 8'h01;
    regWrData = 8'h13;
    regWrEn = 1;
    @(posedge core_clk);
    #1 regWrEn = 0;
    sys_rst = 1;
    @(posedge core_clk);
    #1 chk("rstOuts", outs, 8'h00);
    sys_rst = 0;
    @(posedge core_clk);
    #1 chk("postRst", outs | regRdData, 8'h00);
  endtask
  // write, follow the pulses, then read back after self-clear
  task automatic sc(logic [7:0] a, d, first, held);
    @(posedge core_clk);
    #1 regAddr = a;
    regWrData = d;
    regWrEn = 1;
    @(posedge core_clk);
    #1 regWrEn = 0;
    chk("pulse", outs, first);
    repeat (3) @(posedge core_clk);
    #1 chk("held", outs, held);
    regRdEn = 1;
    @(posedge core_clk);
    #1 regRdEn = 0;
    chk("cleared", outs | regRdData, 8'h00);
  endtask
  task automatic printVerdict;
    $display("errors %0d checks %0d", numErrors, checked);
    if (numErrors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    #1 sys_rst = 0;
    sc(8'h01, 8'h10, 8'h10, 8'h10);
    sc(8'h01, 8'h02, 8'h0C, 8'h08);
    sc(8'h4F, 8'h02, 8'h00, 8'h00);
    sc(8'h01, 8'h01, 8'h0B, 8'h08);
    sc(8'h01, 8'h13, 8'h1C, 8'h18);
    sc(8'h01, 8'hEC, 8'h00, 8'h00);
    sc(8'h02, 8'h13, 8'h00, 8'h00);
    rd(8'hFF, 8'h13);
    midReset;
    sc(8'h01, 8'h10, 8'h10, 8'h10);
    printVerdict;
  end
endmodule // srst_soft_reset_control_tb

// ---- rtl/srst_consts.vh ----
// constants for the soft reset control block
`ifndef SRST_CONSTS_VH
`define SRST_CONSTS_VH
`define SRST_ADDR_RESET      8'h01
`define SRST_BIT_LOGIC       0
`define SRST_BIT_FULL        1
`define SRST_BIT_RX          4
`define SRST_REG_RESET_VAL   8'h00
`define SRST_VALID_MASK      8'h13
`define SRST_PULSE_CYCLES    4
`endif

// ---- rtl/srst_pulse_stretch.v ----
// fixed-length pulse generator for one reset output
`timescale 1ns/1ps
module srst_pulse_stretch #(
  parameter CYCLES = 4
) (
  core_clk,
  sys_rst,
  trigger,
  pulseOut
);
  input  wire core_clk;
  input  wire sys_rst;
  input  wire trigger;
  output reg  pulseOut;

  reg [7:0] count_r;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_r  <= 8'h00;
      pulseOut <= 1'b0;
    end else if (trigger) begin
      count_r  <= CYCLES[7:0];
      pulseOut <= 1'b1;
    end else if (count_r != 8'h00) begin
      count_r  <= count_r - 8'h01;
      pulseOut <= (count_r != 8'h01);
    end else begin
      pulseOut <= 1'b0;
    end
  end
endmodule // srst_pulse_stretch

// ---- rtl/srst_soft_reset_control.v ----
// soft reset control register and reset pulse generation
`timescale 1ns/1ps
`include "srst_consts.vh"

// Functional notes
// - bit four pulses receiver reset, self-clears
// - bit one resets core logic and registers, not the receiver
// - bit zero resets logic, keeps registers
// - logic-only reset reloads strapped registers
// - logic-only reset restores listed registers' defaults
module srst_soft_reset_control #(
  parameter PULSE_CYCLES = `SRST_PULSE_CYCLES
) (
  core_clk,
  sys_rst,
  regWrEn,
  regRdEn,
  regAddr,
  regWrData,
  regRdData,
  rxResetOut,
  coreLogicResetOut,
  regFileResetOut,
  strapReloadOut,
  defaultRestoreOut
);
  input  wire       core_clk;
  input  wire       sys_rst;
  input  wire       regWrEn;
  input  wire       regRdEn;
  input  wire [7:0] regAddr;
  input  wire [7:0] regWrData;
  output reg  [7:0] regRdData;
  output wire       rxResetOut;
  output wire       coreLogicResetOut;
  output reg        regFileResetOut;
  output reg        strapReloadOut;
  output reg        defaultRestoreOut;

  // register layout: bit four receiver reset, bit one full reset,
  // bit zero logic-only reset; all other bits are not implemented

  // write decode, masked to the implemented bits
  wire       hit;
  wire       rdHit;
  wire [7:0] wrMasked;
  wire       rxTrig;
  wire       fullTrig;
  wire       logicTrig;
  wire       logicOnlyTrig;
  wire       coreTrig;

  // register image: bits set on write, cleared next cycle
  reg  [7:0] ctrl_r;
  reg  [7:0] ctrlNxt;

  // next values of the registered outputs
  reg  [7:0] rdDataNxt;
  reg        regFileNxt;
  reg        strapNxt;
  reg        restoreNxt;

  assign hit           = regWrEn && (regAddr == `SRST_ADDR_RESET);
  assign rdHit         = regRdEn && (regAddr == `SRST_ADDR_RESET);
  assign wrMasked      = regWrData & `SRST_VALID_MASK;
  assign rxTrig        = hit && wrMasked[`SRST_BIT_RX];
  assign fullTrig      = hit && wrMasked[`SRST_BIT_FULL];
  assign logicTrig     = hit && wrMasked[`SRST_BIT_LOGIC];
  // full reset wins when both core bits are written together
  assign logicOnlyTrig = logicTrig && !fullTrig;
  assign coreTrig      = fullTrig || logicTrig;

  // self-clearing: a written value is held for one cycle only
  always @* begin
    ctrlNxt = `SRST_REG_RESET_VAL;
    if (hit) begin
      ctrlNxt = wrMasked;
    end
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= `SRST_REG_RESET_VAL;
    end else begin
      ctrl_r <= ctrlNxt;
    end
  end

  // readback: implemented bits only, zero for other addresses
  always @* begin
    rdDataNxt = 8'h00;
    if (rdHit) begin
      rdDataNxt = ctrl_r & `SRST_VALID_MASK;
    end
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= rdDataNxt;
    end
  end

  // one-cycle strobes to the register file
  always @* begin
    regFileNxt = 1'b0;
    if (fullTrig) begin
      regFileNxt = 1'b1;
    end
  end

  always @* begin
    strapNxt = 1'b0;
    if (logicOnlyTrig) begin
      strapNxt = 1'b1;
    end
  end

  always @* begin
    restoreNxt = 1'b0;
    if (logicOnlyTrig) begin
      restoreNxt = 1'b1;
    end
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regFileResetOut <= 1'b0;
    end else begin
      regFileResetOut <= regFileNxt;
    end
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strapReloadOut <= 1'b0;
    end else begin
      strapReloadOut <= strapNxt;
    end
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      defaultRestoreOut <= 1'b0;
    end else begin
      defaultRestoreOut <= restoreNxt;
    end
  end

  // receiver and core resets are stretched; a new write restarts the count

  srst_pulse_stretch #(
    .CYCLES(PULSE_CYCLES)
  ) uRx (
    .core_clk(core_clk),
    .sys_rst (sys_rst),
    .trigger (rxTrig),
    .pulseOut(rxResetOut)
  );

  srst_pulse_stretch #(
    .CYCLES(PULSE_CYCLES)
  ) uCore (
    .core_clk(core_clk),
    .sys_rst (sys_rst),
    .trigger (coreTrig),
    .pulseOut(coreLogicResetOut)
  );
endmodule // srst_soft_reset_control
